// >>> fmioc_pkg.sv
// Constants, types and decode helpers for the fixed memory and I/O controller
// Behaviour
// - Every memory is 64 bits; no realignment
// - SRAM chip enable and address strobe together
// - SRAM strobes one clock after transfer start
// - Writes: byte enables by size; reads: output enable
// - Burst: step low three clocks; else high
// - No initial SRAM wait, no throttling
// - Each transfer completes before the next starts
// - Deselect cycle after every SRAM access
// - Flash single-beat only, never burst
// - One shared flash output enable on reads
// - Flash writes qualified per byte lane
// - Flash select always; enables only on writes
// - Flash acknowledge delayed fixed clock count
// - I/O handled like flash, slow single-beat
// - I/O takes writes of any size
// - I/O writes reuse the shared byte enables
// - Separate access time per I/O select
// - Only fast pipelined-burst SRAM supported
// - SRAM two low address bits from processor
// - Unsupported transfers end with error acknowledge
// - Claim only four transfer type codes
// - Two top address bits pick region
// - Acknowledge once per data beat
package fmioc_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int FLASH_TIME_NS = 200;
  localparam int FLASH_WAIT_CLKS =
    (FLASH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IO0_TIME_NS = 200;
  localparam int IO1_TIME_NS = 100;
  localparam int IO0_WAIT_CLKS =
    (IO0_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IO1_WAIT_CLKS =
    (IO1_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] BURST_STEPS = 3'h3;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_ZERO = 8'h00;

  //////////////////////////////////////////////////////////////////////////
  // Transfer type codes, first bit of the bus as msb
  localparam logic [4:0] XFER_WR_FLUSH = 5'h02;
  localparam logic [4:0] XFER_WR_KILL = 5'h06;
  localparam logic [4:0] XFER_READ = 5'h0a;
  localparam logic [4:0] XFER_READ_RWIM = 5'h0e;

  // Regions from the two top address bits
  localparam logic [1:0] REG_SRAM = 2'h0;
  localparam logic [1:0] REG_NONE = 2'h1;
  localparam logic [1:0] REG_IO = 2'h2;
  localparam logic [1:0] REG_FLASH = 2'h3;
  localparam int ADDR_REG_HI = 31;
  localparam int ADDR_REG_LO = 30;
  localparam int ADDR_IOSEL = 2;
  localparam int ADDR_WORD_HI = 4;
  localparam int ADDR_WORD_LO = 3;

  localparam logic [2:0] SIZE_DWORD = 3'h0;
  localparam logic [7:0] LANES_ALL = 8'hff;
  localparam logic [7:0] LANES_NONE = 8'h00;

  //////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SRAM = 5'h02,
    ST_DESEL = 5'h04,
    ST_SLOW = 5'h08,
    ST_ERR = 5'h10
  } fmioc_state_t;

  typedef struct packed {
    logic error;
    logic [1:0] region;
    logic write;
    logic burst;
    logic io_sel;
    logic [7:0] lanes;
    logic [1:0] word;
  } fmioc_req_t;

  typedef struct packed {
    logic sram_address_strobe_n;
    logic sram_chip_enable_n;
    logic sram_output_enable_n;
    logic burst_step_n;
    logic [7:0] byte_write_enable_n;
    logic [1:0] sram_addr_lsb;
    logic flash_chip_select_n;
    logic flash_output_enable_n;
    logic [1:0] io_chip_select_n;
    logic io_output_enable_n;
    logic transfer_acknowledge_n;
    logic address_acknowledge_n;
    logic transfer_error_ack_n;
  } fmioc_pins_t;

  localparam fmioc_pins_t PINS_IDLE = '{
    sram_address_strobe_n: 1'b1, sram_chip_enable_n: 1'b1,
    sram_output_enable_n: 1'b1, burst_step_n: 1'b1,
    byte_write_enable_n: 8'hff, sram_addr_lsb: 2'h0,
    flash_chip_select_n: 1'b1, flash_output_enable_n: 1'b1,
    io_chip_select_n: 2'h3, io_output_enable_n: 1'b1,
    transfer_acknowledge_n: 1'b1, address_acknowledge_n: 1'b1,
    transfer_error_ack_n: 1'b1};

  //////////////////////////////////////////////////////////////////////////
  // Byte lanes from size and low address; lane 0 is the top data byte
  function automatic logic [7:0] lane_mask(input logic [2:0] size,
                                           input logic [2:0] offs);
    logic [15:0] run;
    run = 16'h0000;
    if (size == SIZE_DWORD) begin
      run = {8'h00, LANES_ALL};
    end else begin
      run = (16'h0001 << size) - 16'h0001;
    end
    run = run << offs;
    lane_mask = run[7:0];
  endfunction : lane_mask

  function automatic logic type_claimed(input logic [4:0] code);
    type_claimed = (code == XFER_WR_FLUSH) || (code == XFER_WR_KILL) ||
                   (code == XFER_READ) || (code == XFER_READ_RWIM);
  endfunction : type_claimed

endpackage : fmioc_pkg

// >>> fmioc_reqbuf.sv
// Two-entry fall-through request buffer with valid and ready on both sides
`timescale 1ns/100ps
module fmioc_reqbuf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] DEPTH_CNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] rd_ptr;
    logic [PW-1:0] wr_ptr;
    logic [PW:0] count;
  } fmioc_buf_t;

  fmioc_buf_t st_ff;
  fmioc_buf_t nxt_st;
  logic empty;
  logic push;
  logic pop;
  logic bypass;

  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == PTR_LAST) ? '0 : p + 1'b1;
  endfunction : step

  //////////////////////////////////////////////////////////////////////////
  // A word arriving while empty may pass straight through, no latency
  assign empty = (st_ff.count == '0);
  assign in_ready_out = (st_ff.count != DEPTH_CNT);
  assign out_valid_out = !empty || in_valid_in;
  assign out_data_out = empty ? in_data_in : st_ff.mem[st_ff.rd_ptr];
  assign bypass = empty && in_valid_in && out_ready_in;
  assign push = in_valid_in && in_ready_out && !bypass;
  assign pop = !empty && out_ready_in;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wr_ptr] = in_data_in;
      nxt_st.wr_ptr = step(st_ff.wr_ptr);
    end
    if (pop) begin
      nxt_st.rd_ptr = step(st_ff.rd_ptr);
    end
    if (push && !pop) begin
      nxt_st.count = st_ff.count + 1'b1;
    end else if (pop && !push) begin
      nxt_st.count = st_ff.count - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_ff <= '0;
    end else if (ce_in) begin
      st_ff <= nxt_st;
    end
  end

endmodule : fmioc_reqbuf

// >>> fmioc_top.sv
// Fixed memory and I/O controller: decode, request buffer and bus cycler
`timescale 1ns/100ps
module fmioc_top #(
  parameter logic [7:0] FLASH_WAIT =
    8'(fmioc_pkg::FLASH_WAIT_CLKS),
  parameter logic [7:0] IO0_WAIT = 8'(fmioc_pkg::IO0_WAIT_CLKS),
  parameter logic [7:0] IO1_WAIT = 8'(fmioc_pkg::IO1_WAIT_CLKS)
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Processor address tenure
  input wire logic transfer_start_n_in,
  input wire logic [4:0] transfer_type_in,
  input wire logic [2:0] transfer_size_in,
  input wire logic burst_n_in,
  input wire logic [31:0] addr_in,
  // Processor acknowledges
  output logic transfer_acknowledge_n_out,
  output logic address_acknowledge_n_out,
  output logic transfer_error_ack_n_out,
  output logic req_ready_out,
  // SRAM controls
  output logic sram_address_strobe_n_out,
  output logic sram_chip_enable_n_out,
  output logic sram_output_enable_n_out,
  output logic burst_step_n_out,
  output logic [1:0] sram_addr_lsb_out,
  // Shared byte-write enables
  output logic [7:0] byte_write_enable_n_out,
  // Flash controls
  output logic flash_chip_select_n_out,
  output logic flash_output_enable_n_out,
  // I/O controls
  output logic [1:0] io_chip_select_n_out,
  output logic io_output_enable_n_out
);

  localparam int REQ_W = $bits(fmioc_pkg::fmioc_req_t);

  typedef struct packed {
    fmioc_pkg::fmioc_state_t state;
    logic data_phase;
    logic [7:0] cnt;
    fmioc_pkg::fmioc_pins_t pins;
  } fmioc_ctl_t;

  fmioc_ctl_t st_ff;
  fmioc_ctl_t nxt_st;
  fmioc_pkg::fmioc_req_t in_req;
  fmioc_pkg::fmioc_req_t rq;
  logic [REQ_W-1:0] rq_bits;
  logic rq_valid;
  logic rq_take;
  logic [1:0] region;
  logic claimed;

  //////////////////////////////////////////////////////////////////////////
  // Start decode
  assign region = addr_in[fmioc_pkg::ADDR_REG_HI:fmioc_pkg::ADDR_REG_LO];
  assign claimed = fmioc_pkg::type_claimed(transfer_type_in);

  always_comb begin
    in_req = '0;
    in_req.region = region;
    in_req.write = !transfer_type_in[3];
    in_req.burst = !burst_n_in;
    in_req.io_sel = addr_in[fmioc_pkg::ADDR_IOSEL];
    in_req.word = addr_in[fmioc_pkg::ADDR_WORD_HI:fmioc_pkg::ADDR_WORD_LO];
    // Bursts use whole 64-bit lanes, no narrow sub-cycles
    if (!burst_n_in) begin
      in_req.lanes = fmioc_pkg::LANES_ALL;
    end else begin
      in_req.lanes = fmioc_pkg::lane_mask(transfer_size_in,
                                          addr_in[2:0]);
    end
    // Slow regions cannot burst; unmapped space has no target
    in_req.error = !claimed || (region == fmioc_pkg::REG_NONE) ||
                   (!burst_n_in && region != fmioc_pkg::REG_SRAM);
  end

  //////////////////////////////////////////////////////////////////////////
  // Request buffer; cycler drains only when idle
  fmioc_reqbuf #(
    .WIDTH(REQ_W),
    .DEPTH(2)
  ) u_reqbuf (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .in_valid_in(!transfer_start_n_in),
    .in_ready_out(req_ready_out),
    .in_data_in(in_req),
    .out_valid_out(rq_valid),
    .out_ready_in(rq_take),
    .out_data_out(rq_bits)
  );

  assign rq = fmioc_pkg::fmioc_req_t'(rq_bits);
  // No overlap of tenures: next start waits for the idle state
  assign rq_take = (st_ff.state == fmioc_pkg::ST_IDLE);

  //////////////////////////////////////////////////////////////////////////
  // Cycler
  always_comb begin
    nxt_st = st_ff;
    case (st_ff.state)
      fmioc_pkg::ST_IDLE: begin
        nxt_st.pins = fmioc_pkg::PINS_IDLE;
        nxt_st.data_phase = 1'b0;
        nxt_st.cnt = fmioc_pkg::CNT_ZERO;
        if (rq_valid) begin
          if (rq.error) begin
            nxt_st.state = fmioc_pkg::ST_ERR;
            nxt_st.pins.transfer_error_ack_n = 1'b0;
            nxt_st.pins.address_acknowledge_n = 1'b0;
          end else if (rq.region == fmioc_pkg::REG_SRAM) begin
            nxt_st.state = fmioc_pkg::ST_SRAM;
            // Strobe and enable leave together, no wait state
            nxt_st.pins.sram_chip_enable_n = 1'b0;
            nxt_st.pins.sram_address_strobe_n = 1'b0;
            nxt_st.pins.sram_addr_lsb = rq.word;
            nxt_st.pins.sram_output_enable_n = rq.write;
            if (rq.write) begin
              nxt_st.pins.byte_write_enable_n = ~rq.lanes;
            end
            if (rq.burst) begin
              nxt_st.cnt = {5'h00, fmioc_pkg::BURST_STEPS};
            end
          end else begin
            nxt_st.state = fmioc_pkg::ST_SLOW;
            if (rq.write) begin
              nxt_st.pins.byte_write_enable_n = ~rq.lanes;
            end
            if (rq.region == fmioc_pkg::REG_FLASH) begin
              nxt_st.pins.flash_chip_select_n = 1'b0;
              nxt_st.pins.flash_output_enable_n = rq.write;
              nxt_st.cnt = FLASH_WAIT - fmioc_pkg::CNT_ONE;
            end else begin
              nxt_st.pins.io_chip_select_n[rq.io_sel] = 1'b0;
              nxt_st.pins.io_output_enable_n = rq.write;
              nxt_st.cnt = (rq.io_sel ? IO1_WAIT : IO0_WAIT) -
                           fmioc_pkg::CNT_ONE;
            end
            if (nxt_st.cnt == fmioc_pkg::CNT_ZERO) begin
              nxt_st.pins.transfer_acknowledge_n = 1'b0;
              nxt_st.pins.address_acknowledge_n = 1'b0;
            end
          end
        end
      end
      fmioc_pkg::ST_SRAM: begin
        nxt_st.pins.sram_address_strobe_n = 1'b1;
        if (!st_ff.data_phase) begin
          // First beat right after the strobe
          nxt_st.data_phase = 1'b1;
          nxt_st.pins.transfer_acknowledge_n = 1'b0;
          nxt_st.pins.burst_step_n =
            (st_ff.cnt == fmioc_pkg::CNT_ZERO);
          nxt_st.pins.address_acknowledge_n =
            (st_ff.cnt != fmioc_pkg::CNT_ZERO);
        end else if (st_ff.cnt == fmioc_pkg::CNT_ZERO) begin
          // Writes keep streaming unless the part is deselected
          nxt_st.state = fmioc_pkg::ST_DESEL;
          nxt_st.pins = fmioc_pkg::PINS_IDLE;
          nxt_st.pins.sram_address_strobe_n = 1'b0;
        end else begin
          nxt_st.cnt = st_ff.cnt - fmioc_pkg::CNT_ONE;
          nxt_st.pins.transfer_acknowledge_n = 1'b0;
          nxt_st.pins.burst_step_n =
            (nxt_st.cnt == fmioc_pkg::CNT_ZERO);
          nxt_st.pins.address_acknowledge_n =
            (nxt_st.cnt != fmioc_pkg::CNT_ZERO);
        end
      end
      fmioc_pkg::ST_DESEL: begin
        nxt_st.state = fmioc_pkg::ST_IDLE;
        nxt_st.pins = fmioc_pkg::PINS_IDLE;
      end
      fmioc_pkg::ST_SLOW: begin
        if (!st_ff.pins.transfer_acknowledge_n) begin
          nxt_st.state = fmioc_pkg::ST_IDLE;
          nxt_st.pins = fmioc_pkg::PINS_IDLE;
        end else begin
          // Fixed delay covers reads and program launch alike
          nxt_st.cnt = st_ff.cnt - fmioc_pkg::CNT_ONE;
          if (nxt_st.cnt == fmioc_pkg::CNT_ZERO) begin
            nxt_st.pins.transfer_acknowledge_n = 1'b0;
            nxt_st.pins.address_acknowledge_n = 1'b0;
          end
        end
      end
      fmioc_pkg::ST_ERR: begin
        nxt_st.state = fmioc_pkg::ST_IDLE;
        nxt_st.pins = fmioc_pkg::PINS_IDLE;
      end
      default: begin
        nxt_st.state = fmioc_pkg::ST_IDLE;
        nxt_st.pins = fmioc_pkg::PINS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_ff.state <= fmioc_pkg::ST_IDLE;
      st_ff.data_phase <= 1'b0;
      st_ff.cnt <= fmioc_pkg::CNT_ZERO;
      st_ff.pins <= fmioc_pkg::PINS_IDLE;
    end else if (ce_in) begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pins straight from flip-flops
  assign transfer_acknowledge_n_out = st_ff.pins.transfer_acknowledge_n;
  assign address_acknowledge_n_out = st_ff.pins.address_acknowledge_n;
  assign transfer_error_ack_n_out = st_ff.pins.transfer_error_ack_n;
  assign sram_address_strobe_n_out = st_ff.pins.sram_address_strobe_n;
  assign sram_chip_enable_n_out = st_ff.pins.sram_chip_enable_n;
  assign sram_output_enable_n_out = st_ff.pins.sram_output_enable_n;
  assign burst_step_n_out = st_ff.pins.burst_step_n;
  assign sram_addr_lsb_out = st_ff.pins.sram_addr_lsb;
  assign byte_write_enable_n_out = st_ff.pins.byte_write_enable_n;
  assign flash_chip_select_n_out = st_ff.pins.flash_chip_select_n;
  assign flash_output_enable_n_out = st_ff.pins.flash_output_enable_n;
  assign io_chip_select_n_out = st_ff.pins.io_chip_select_n;
  assign io_output_enable_n_out = st_ff.pins.io_output_enable_n;

endmodule : fmioc_top

// >>> fmioc_checker.sv
// Port assertions for the fixed memory and I/O controller
`timescale 1ns/100ps
module fmioc_checker #(
  parameter logic [7:0] FLASH_WAIT = 8'h0a,
  parameter logic [7:0] IO1_WAIT = 8'h05
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Request
  input wire logic transfer_start_n_in,
  input wire logic [4:0] transfer_type_in,
  input wire logic burst_n_in,
  input wire logic [31:0] addr_in,
  // Answers and memory controls
  input wire logic transfer_acknowledge_n_out,
  input wire logic address_acknowledge_n_out,
  input wire logic transfer_error_ack_n_out,
  input wire logic req_ready_out,
  input wire logic sram_address_strobe_n_out,
  input wire logic sram_chip_enable_n_out,
  input wire logic burst_step_n_out,
  input wire logic [1:0] sram_addr_lsb_out,
  input wire logic flash_chip_select_n_out,
  input wire logic [1:0] io_chip_select_n_out
);
  localparam int FW = int'(FLASH_WAIT);
  localparam int IW1 = int'(IO1_WAIT);
  // Open transfer count; timing checks assume ce_in stays high
  logic [1:0] open_ff;
  logic [1:0] nxt_open;
  logic take, go, bad, sram_go, flash_go, io_go;
  always_comb begin
    take = !transfer_start_n_in && ce_in && req_ready_out;
    go = take && open_ff == 2'h0;
    nxt_open = open_ff + 2'(take) - 2'(!address_acknowledge_n_out && ce_in);
    bad = !(transfer_type_in inside {5'h02, 5'h06, 5'h0a, 5'h0e}) ||
      addr_in[31:30] == 2'h1 || (!burst_n_in && addr_in[31:30] != 2'h0);
    sram_go = go && !bad && addr_in[31:30] == 2'h0;
    flash_go = go && !bad && addr_in[31:30] == 2'h3;
    io_go = go && !bad && addr_in[31:30] == 2'h2;
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      open_ff <= 2'h0;
    end else begin
      open_ff <= nxt_open;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  chk_ce_strobe: assert property (
    $fell(sram_chip_enable_n_out) |-> !sram_address_strobe_n_out)
    else $error("sram enable without strobe");
  chk_sram_start: assert property (
    sram_go |=> !sram_chip_enable_n_out && flash_chip_select_n_out)
    else $error("sram access not started");
  chk_burst_step: assert property (
    sram_go && !burst_n_in |=> burst_step_n_out ##1
      (!burst_step_n_out) [*3] ##1 burst_step_n_out)
    else $error("burst step not three clocks");
  chk_burst_desel: assert property (
    sram_go && !burst_n_in |-> ##2 (!transfer_acknowledge_n_out) [*4]
      ##1 (!sram_address_strobe_n_out && sram_chip_enable_n_out))
    else $error("burst beats or deselect wrong");
  chk_flash_ack: assert property (
    flash_go |-> ##FW (!transfer_acknowledge_n_out &&
      !flash_chip_select_n_out))
    else $error("flash acknowledge late or early");
  chk_error_ack: assert property (
    go && bad |=> !transfer_error_ack_n_out && !address_acknowledge_n_out &&
      sram_chip_enable_n_out && flash_chip_select_n_out &&
      io_chip_select_n_out == 2'h3)
    else $error("refused transfer not ended by error");
  chk_io_select: assert property (
    io_go |=> io_chip_select_n_out == ($past(addr_in[2]) ? 2'h1 : 2'h2))
    else $error("wrong io select");
  chk_io_fast: assert property (
    io_go && addr_in[2] |-> ##IW1 !transfer_acknowledge_n_out)
    else $error("fast io acknowledge wrong");
  chk_lsb_word: assert property (
    sram_go |=> sram_addr_lsb_out == $past(addr_in[4:3]))
    else $error("sram low address wrong");
  cov_burst: cover property (sram_go && !burst_n_in);
  cov_flash: cover property (flash_go);
  cov_error: cover property (go && bad);
endmodule : fmioc_checker

// >>> fmioc_cpu_model.sv
// Processor bus model: issues transfers and records the answers
`timescale 1ns/100ps
module fmioc_cpu_model #(
  parameter int FLASH_GAP = 4
) (
  // Clock
  input wire logic clk_in,
  // Address tenure
  output logic transfer_start_n_out,
  output logic [4:0] transfer_type_out,
  output logic [2:0] transfer_size_out,
  output logic burst_n_out,
  output logic [31:0] addr_out,
  // Answers
  input wire logic req_ready_in,
  input wire fmioc_pkg::fmioc_pins_t pins_in
);
  initial begin
    transfer_start_n_out = 1'b1;
    {transfer_type_out, transfer_size_out, burst_n_out, addr_out} = '0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Released lines go inverted so a stale value never looks valid
  task automatic push(input logic [40:0] req, output logic rdy);
    @(posedge clk_in);
    #1;
    transfer_start_n_out = 1'b0;
    {transfer_type_out, transfer_size_out, burst_n_out, addr_out} = req;
    rdy = req_ready_in;
    @(posedge clk_in);
    #1;
    transfer_start_n_out = 1'b1;
    {transfer_type_out, transfer_size_out, burst_n_out, addr_out} = ~req;
  endtask : push
  task automatic issue(input logic [40:0] req, output logic [7:0] lat,
                       output logic [7:0] beats, output logic err,
                       output logic [7:0] bwe, output logic [3:0] sel);
    logic rdy;
    lat = 8'h00;
    beats = 8'h00;
    err = 1'b0;
    bwe = 8'hff;
    sel = 4'h0;
    push(req, rdy);
    for (int k = 1; k < 40; k++) begin
      @(negedge clk_in);
      bwe &= pins_in.byte_write_enable_n;
      sel |= {~pins_in.sram_chip_enable_n, ~pins_in.flash_chip_select_n,
              ~&pins_in.io_chip_select_n, ~(pins_in.sram_output_enable_n &
              pins_in.flash_output_enable_n & pins_in.io_output_enable_n)};
      if (lat == 8'h00 && !(pins_in.transfer_acknowledge_n &&
          pins_in.transfer_error_ack_n)) lat = 8'(k);
      beats += 8'(!pins_in.transfer_acknowledge_n);
      err |= !pins_in.transfer_error_ack_n;
      if (!pins_in.address_acknowledge_n) break;
    end
    // Flash program is slow; wait before touching flash again
    if (!req[39] && req[31:30] == 2'h3) begin
      repeat (FLASH_GAP) @(posedge clk_in);
    end
    @(posedge clk_in);
  endtask : issue
endmodule : fmioc_cpu_model

// >>> tb_fmioc_top.sv
// Self-checking testbench for the fixed memory and I/O controller
`timescale 1ns/100ps
module tb_fmioc_top;
  localparam logic [7:0] FW = 8'(fmioc_pkg::FLASH_WAIT_CLKS);
  localparam logic [7:0] IW0 = 8'(fmioc_pkg::IO0_WAIT_CLKS);
  localparam logic [7:0] IW1 = 8'(fmioc_pkg::IO1_WAIT_CLKS);
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic ce_in = 1'b1;
  logic start_n, burst_n, ready, rdy;
  logic [4:0] type_w, ty;
  logic [2:0] size_w, sz;
  logic [31:0] addr_w, r, a;
  logic [4:0] types [4] = '{5'h02, 5'h06, 5'h0a, 5'h0e};
  wire fmioc_pkg::fmioc_pins_t pins;
  int n_mismatch = 0;
  int num_checks = 0;
  int n;
  integer seed = 32'hb9e6c1b2;
  always #10 clk_in = ~clk_in;
  fmioc_top #(.FLASH_WAIT(FW), .IO0_WAIT(IW0), .IO1_WAIT(IW1)) u_dut (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .transfer_start_n_in(start_n),
    .transfer_type_in(type_w),
    .transfer_size_in(size_w),
    .burst_n_in(burst_n),
    .addr_in(addr_w),
    .transfer_acknowledge_n_out(pins.transfer_acknowledge_n),
    .address_acknowledge_n_out(pins.address_acknowledge_n),
    .transfer_error_ack_n_out(pins.transfer_error_ack_n),
    .req_ready_out(ready),
    .sram_address_strobe_n_out(pins.sram_address_strobe_n),
    .sram_chip_enable_n_out(pins.sram_chip_enable_n),
    .sram_output_enable_n_out(pins.sram_output_enable_n),
    .burst_step_n_out(pins.burst_step_n),
    .sram_addr_lsb_out(pins.sram_addr_lsb),
    .byte_write_enable_n_out(pins.byte_write_enable_n),
    .flash_chip_select_n_out(pins.flash_chip_select_n),
    .flash_output_enable_n_out(pins.flash_output_enable_n),
    .io_chip_select_n_out(pins.io_chip_select_n),
    .io_output_enable_n_out(pins.io_output_enable_n)
  );
  fmioc_cpu_model u_cpu (
    .clk_in(clk_in),
    .transfer_start_n_out(start_n),
    .transfer_type_out(type_w),
    .transfer_size_out(size_w),
    .burst_n_out(burst_n),
    .addr_out(addr_w),
    .req_ready_in(ready),
    .pins_in(pins)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Write lanes: offs up to offs+size-1, size 0 meaning eight, clipped at lane 7
  function automatic logic [7:0] exp_lanes(input logic [2:0] s,
                                           input logic [2:0] o);
    logic [15:0] m;
    m = (s == 3'h0) ? 16'h00ff : (16'h0001 << s) - 16'h0001;
    m = m << o;
    return m[7:0];
  endfunction : exp_lanes
  task automatic idle_check();
    check("idle pins", 8'(pins === fmioc_pkg::PINS_IDLE), 8'h01);
    check("ready", 8'(ready), 8'h01);
  endtask : idle_check
  task automatic run(input logic [40:0] req);
    logic [4:0] t;
    logic [2:0] s;
    logic bn, err, bad;
    logic [31:0] ad;
    logic [7:0] lat, beats, bwe, elat, eb;
    logic [3:0] sel, esel;
    {t, s, bn, ad} = req;
    bad = !(t inside {5'h02, 5'h06, 5'h0a, 5'h0e}) || ad[31:30] == 2'h1
      || (!bn && ad[31:30] != 2'h0);
    eb = (t[3] || bad) ? 8'hff : bn ? ~exp_lanes(s, ad[2:0]) : 8'h00;
    elat = (ad[31:30] == 2'h0) ? 8'h02 : (ad[31:30] == 2'h3) ? FW
      : ad[2] ? IW1 : IW0;
    esel = {ad[31:30] == 2'h0, ad[31:30] == 2'h3, ad[31:30] == 2'h2, t[3]};
    if (bad) begin
      elat = 8'h01;
      esel = 4'h0;
    end
    u_cpu.issue(req, lat, beats, err, bwe, sel);
    check("latency", lat, elat);
    check("beats", beats, bad ? 8'h00 : bn ? 8'h01 : 8'h04);
    check("error", 8'(err), 8'(bad));
    check("byte enables", bwe, eb);
    check("selects", 8'(sel), 8'(esel));
  endtask : run
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_in);
    #1;
    idle_check();
    rstn_in = 1'b1;
    run({5'h0e, 3'h0, 1'b0, 32'h0000_0018});
    run({5'h06, 3'h0, 1'b0, 32'h0000_0008});
    for (int i = 0; i < 8; i++) run({5'h02, 3'(i), 1'b1, 32'h0000_0005});
    for (int i = 0; i < 32; i++) run({5'(i), 3'h1, 1'b1, 32'h0000_0010});
    run({5'h0a, 3'h0, 1'b1, 32'hc000_0000});
    run({5'h02, 3'h2, 1'b1, 32'hc000_0002});
    run({5'h02, 3'h2, 1'b1, 32'h8000_0000});
    run({5'h0a, 3'h1, 1'b1, 32'h8000_0004});
    run({5'h0a, 3'h0, 1'b1, 32'h4000_0000});
    run({5'h0e, 3'h0, 1'b0, 32'hc000_0000});
    for (int i = 0; i < 60; i++) begin
      r = $random(seed);
      a = $random(seed);
      ty = (r[4:2] == 3'h0) ? r[9:5] : types[r[1:0]];
      sz = r[12:10];
      if (!ty[3] && a[31:30] == 2'h3) sz = r[15] ? 3'h2 : 3'h4;
      run({ty, sz, |r[14:13], a});
    end
    // Two starts queue behind a slow access; a third is dropped
    u_cpu.push({5'h0a, 3'h0, 1'b1, 32'hc000_0000}, rdy);
    u_cpu.push({5'h0a, 3'h0, 1'b1, 32'h0000_0000}, rdy);
    u_cpu.push({5'h02, 3'h4, 1'b1, 32'h8000_0000}, rdy);
    u_cpu.push({5'h0a, 3'h0, 1'b1, 32'h0000_0000}, rdy);
    check("ready when full", 8'(rdy), 8'h00);
    n = 0;
    repeat (60) begin
      @(negedge clk_in);
      n += int'(pins.address_acknowledge_n === 1'b0);
    end
    check("served", 8'(n), 8'h03);
    u_cpu.push({5'h0a, 3'h0, 1'b1, 32'hc000_0000}, rdy);
    repeat (3) @(posedge clk_in);
    #1;
    rstn_in = 1'b0;
    #2;
    idle_check();
    @(posedge clk_in);
    #1;
    rstn_in = 1'b1;
    // Frozen by the enable: a start is ignored, nothing moves
    ce_in = 1'b0;
    u_cpu.push({5'h0a, 3'h0, 1'b1, 32'h0000_0000}, rdy);
    @(posedge clk_in);
    #1;
    idle_check();
    ce_in = 1'b1;
    run({5'h0a, 3'h0, 1'b0, 32'h0000_0000});
    tally_and_finish();
  end
  // Traffic needs under two thousand cycles; 20000 cycles is far beyond that, a hang
  initial begin
    #400000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : tb_fmioc_top
bind fmioc_top fmioc_checker #(.FLASH_WAIT(FLASH_WAIT), .IO1_WAIT(IO1_WAIT))
  u_chk (.*);
